// File: vc_bus_pkg.sv
// Functional notes
// R1 - Refresh request yields refresh cycle, enables
// R2 - Simultaneous requests: refresh first, vector next
// R3 - Step clock runs, halts during vector wait
// R4 - Spare cycles to vector, step pulse each
// R5 - Grant acknowledge from grant time window
// R6 - Inhibit strap suppresses refresh requests
// R7 - Refresh enable drives raster address lines
// R8 - Top five address bits give group select
// R9 - Bus ack on group with read/ack
// R10 - Status, control, column register addresses
// R11 - Status read enables data bus driver
// R12 - Enabled events set their own flags
// R13 - Interrupt asserted while any flag set
// R14 - Status write clears flags or fires copy
// R15 - Copy pulse holds copier busy low
// R16 - Column register reloads counter each retrace
// R17 - Column counter zero gives column hit
// R18 - Column register top bit enables cursor
// R19 - Row register reloads, decrements per line
// R20 - Row hit overrides, lights whole line while border blank high
// R21 - Latch samples hits each pixel clock
// R22 - Map select or enable low blanks cursor
// R23 - Flags sticky, events synchronised first
package vc_bus_pkg;
    // Clock and copy pulse timing
    localparam int CLK_PERIOD_NS   = 5;
    localparam int COPY_PULSE_MS   = 6;
    localparam int COPY_PULSE_CYC  = COPY_PULSE_MS * 1000000 / CLK_PERIOD_NS;
    // Step clock half period, width of end-of-cycle step pulse
    localparam int STEP_HALF_CYC   = 2;
    localparam int STEP_PULSE_CYC  = 2;
    // Group decode: upper five address bits
    localparam logic [4:0]  GROUP_MATCH   = 5'h1E;
    // Register byte addresses
    localparam logic [15:0] ADDR_STATUS   = 16'hF740;
    localparam logic [15:0] ADDR_CONTROL  = 16'hF742;
    localparam logic [15:0] ADDR_COLUMN   = 16'hF744;
    localparam logic [15:0] ADDR_ROW      = 16'hF746;
    // Flag and status bit positions
    localparam int FLAG_READY      = 0;
    localparam int FLAG_COPY_DONE  = 1;
    localparam int FLAG_FRAME      = 2;
    localparam int ST_READY_LVL    = 3;
    localparam int ST_BUSY_LVL     = 4;
    localparam int WR_COPY_BIT     = 3;
    localparam int CURSOR_EN_BIT   = 15;
    // Reset values and counter constants
    localparam logic [2:0]  FLAGS_RST     = 3'h0;
    localparam logic [15:0] POS_RST       = 16'h0000;
    localparam logic [14:0] CNT_ONE       = 15'h0001;
    localparam logic [14:0] CNT_ZERO      = 15'h0000;

    // Asynchronous pins, synchronised as one bundle
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        readCmdN;
        logic        writeCmdN;
        logic        writeSyncAckN;
        logic        refreshRequest;
        logic        vectorCycleRequestN;
        logic        cycleStart;
        logic        grantTimeWindow;
        logic        refreshInhibitStrap;
        logic        vectorUnitReady;
        logic        copierBusyN;
        logic        frameSync;
        logic        cursorPixelClock;
        logic        lineRetraceMarkerN;
        logic        frameRetraceMarkerN;
        logic        lineSync;
        logic        borderBlank;
        logic        mapWriteSelN;
    } pins_t;

    // Owner of the current memory cycle
    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_REFRESH,
        CYC_VECTOR
    } cycle_t;
endpackage

// File: display_bus_status_cursor.sv
`timescale 1ns/1ps
module display_bus_status_cursor #(
    parameter int COPY_CYCLES = vc_bus_pkg::COPY_PULSE_CYC
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire vc_bus_pkg::pins_t pinsIn,
    input  wire logic [13:0]       refreshAddr,
    output logic [13:0]            rasterAddrOut,
    output logic                   rasterAddrOe,
    output logic                   refreshAddressEnableN,
    output logic                   refreshCycleN,
    output logic                   vectorStepClock,
    output logic                   vectorMemoryEnableN,
    output logic                   vectorGrantAckN,
    output logic                   groupSelectN,
    output logic                   busAckN,
    output logic [15:0]            ioDataOut,
    output logic                   ioDataOe,
    output logic                   interruptN,
    output logic                   copyStartPulseN,
    output logic                   copierBusyOut,
    output logic                   copierBusyOe,
    output logic                   cursorVideo
);
    import vc_bus_pkg::*;

    // Synchroniser stages; stage one read only by stage two
    pins_t  meta_q;
    pins_t  pin_q;
    pins_t  last_q;
    // Arbiter state
    cycle_t cycle_q;
    logic   refPend_q;
    logic [7:0] stepCnt_q;
    logic [7:0] stepDiv_q;
    // Bus side state
    logic [2:0]  flags_q;
    logic [2:0]  intEn_q;
    logic [15:0] column_q;
    logic [15:0] row_q;
    logic [31:0] copyCnt_q;
    // Cursor counters and hits
    logic [14:0] xCnt_q;
    logic [14:0] yCnt_q;
    logic        colHit_q;
    logic        rowHit_q;

    // Compare an address against a register address
    function automatic logic hitAddr(input logic [15:0] a, input logic [15:0] r);
        hitAddr = (a == r);
    endfunction

    // Rising edge of a synchronised bit
    function automatic logic rose(input logic now, input logic was);
        rose = now & ~was;
    endfunction

    // Two-flop synchroniser plus history for edge detection
    always_ff @(posedge clk) begin
        meta_q <= pinsIn;
        pin_q  <= meta_q;
        last_q <= pin_q;
    end

    // Edges and decoded strobes
    logic cycEdge;
    logic refEdge;
    logic vecReq;
    logic grpSel;
    logic wrEdge;
    logic pixEdge;
    logic lineEdge;
    logic readyRise;
    logic busyRise;
    logic frameRise;
    assign cycEdge   = rose(pin_q.cycleStart, last_q.cycleStart);
    // Strap present masks every refresh request
    // R6 strap inhibits refresh
    assign refEdge   = rose(pin_q.refreshRequest, last_q.refreshRequest)
                       & ~pin_q.refreshInhibitStrap;
    assign vecReq    = ~pin_q.vectorCycleRequestN;
    // R8 group range decode
    assign grpSel    = (pin_q.addr[15:11] == GROUP_MATCH);
    assign wrEdge    = rose(last_q.writeCmdN, pin_q.writeCmdN) & grpSel;
    assign pixEdge   = rose(pin_q.cursorPixelClock, last_q.cursorPixelClock);
    assign lineEdge  = rose(pin_q.lineSync, last_q.lineSync);
    // R23 events taken from synchronised edges
    assign readyRise = rose(pin_q.vectorUnitReady, last_q.vectorUnitReady);
    assign busyRise  = rose(pin_q.copierBusyN, last_q.copierBusyN);
    assign frameRise = rose(pin_q.frameSync, last_q.frameSync);

    // Pending refresh; a boundary serves pending and new requests alike,
    // so a request landing on a boundary is not served twice
    always_ff @(posedge clk) begin
        if (srst) begin
            refPend_q <= 1'b0;
        end else if (cycEdge) begin
            refPend_q <= 1'b0;
        end else if (refEdge) begin
            refPend_q <= 1'b1;
        end
    end

    // Memory cycle owner chosen at each cycle boundary
    always_ff @(posedge clk) begin
        if (srst) begin
            cycle_q <= CYC_IDLE;
        end else if (cycEdge) begin
            // R1 refresh gets the cycle
            // R2 refresh before vector
            if (refPend_q || refEdge) begin
                cycle_q <= CYC_REFRESH;
            // R4 spare cycles to vector
            end else if (vecReq) begin
                cycle_q <= CYC_VECTOR;
            end else begin
                cycle_q <= CYC_IDLE;
            end
        end
    end

    // Memory cycle enables and indicators
    always_ff @(posedge clk) begin
        if (srst) begin
            refreshAddressEnableN <= 1'b1;
            refreshCycleN         <= 1'b1;
            vectorMemoryEnableN   <= 1'b1;
            vectorGrantAckN       <= 1'b1;
        end else begin
            // R1 refresh enable and indicator
            refreshAddressEnableN <= ~(cycle_q == CYC_REFRESH);
            refreshCycleN         <= ~(cycle_q == CYC_REFRESH);
            // R4 enable held whole cycle
            vectorMemoryEnableN   <= ~(cycle_q == CYC_VECTOR);
            // R5 ack from grant window
            vectorGrantAckN <= ~((cycle_q == CYC_VECTOR) & pin_q.grantTimeWindow);
        end
    end

    // Refresh address onto raster lines while refreshing
    always_ff @(posedge clk) begin
        if (srst) begin
            rasterAddrOut <= 14'h0000;
            rasterAddrOe  <= 1'b0;
        end else begin
            // R7 refresh address drivers
            rasterAddrOut <= refreshAddr;
            rasterAddrOe  <= (cycle_q == CYC_REFRESH);
        end
    end

    // Step pulse counter: loaded as a vector cycle ends
    always_ff @(posedge clk) begin
        if (srst) begin
            stepCnt_q <= 8'h00;
        // R4 one step per vector cycle
        end else if (cycEdge && cycle_q == CYC_VECTOR) begin
            stepCnt_q <= 8'(STEP_PULSE_CYC);
        end else if (stepCnt_q != 8'h00) begin
            stepCnt_q <= stepCnt_q - 8'h01;
        end
    end

    // Free-running divider for the idle step clock
    always_ff @(posedge clk) begin
        if (srst || stepDiv_q == 8'(STEP_HALF_CYC - 1)) begin
            stepDiv_q <= 8'h00;
        end else begin
            stepDiv_q <= stepDiv_q + 8'h01;
        end
    end

    // Step clock: end pulse, halted while request waits, else free
    always_ff @(posedge clk) begin
        if (srst) begin
            vectorStepClock <= 1'b0;
        end else if (stepCnt_q != 8'h00) begin
            vectorStepClock <= 1'b1;
        // R3 halt until cycle ends
        end else if (vecReq || cycle_q == CYC_VECTOR) begin
            vectorStepClock <= 1'b0;
        end else if (stepDiv_q == 8'(STEP_HALF_CYC - 1)) begin
            vectorStepClock <= ~vectorStepClock;
        end
    end

    // Group select and bus acknowledge
    always_ff @(posedge clk) begin
        if (srst) begin
            groupSelectN <= 1'b1;
            busAckN      <= 1'b1;
        end else begin
            groupSelectN <= ~grpSel;
            // R9 acknowledge on read or sync ack
            busAckN <= ~(grpSel & (~pin_q.readCmdN | ~pin_q.writeSyncAckN));
        end
    end

    // Status word read driver
    always_ff @(posedge clk) begin
        if (srst) begin
            ioDataOut <= 16'h0000;
            ioDataOe  <= 1'b0;
        end else begin
            ioDataOut <= 16'h0000;
            ioDataOut[2:0]          <= flags_q;
            ioDataOut[ST_READY_LVL] <= pin_q.vectorUnitReady;
            ioDataOut[ST_BUSY_LVL]  <= pin_q.copierBusyN;
            // R11 read command with status address
            ioDataOe <= ~pin_q.readCmdN & grpSel & hitAddr(pin_q.addr, ADDR_STATUS);
        end
    end

    // Control and cursor position registers
    always_ff @(posedge clk) begin
        if (srst) begin
            intEn_q  <= FLAGS_RST;
            column_q <= POS_RST;
            row_q    <= POS_RST;
        end else if (wrEdge) begin
            // R10 register write decode
            if (hitAddr(pin_q.addr, ADDR_CONTROL)) begin
                intEn_q <= pin_q.wdata[2:0];
            end
            // R16 column load strobe
            // R18 top bit is cursor enable
            if (hitAddr(pin_q.addr, ADDR_COLUMN)) begin
                column_q <= pin_q.wdata;
            end
            // R19 row load strobe
            if (hitAddr(pin_q.addr, ADDR_ROW)) begin
                row_q <= pin_q.wdata;
            end
        end
    end

    // Sticky flags; a set in the clearing cycle survives
    logic       statWr;
    logic [2:0] flagSet;
    logic [2:0] flagClr;
    assign statWr  = wrEdge & hitAddr(pin_q.addr, ADDR_STATUS);
    // R12 enabled event sets flag
    assign flagSet = intEn_q & {frameRise, busyRise, readyRise};
    // R14 data bits pick clears
    assign flagClr = statWr ? pin_q.wdata[2:0] : 3'h0;
    always_ff @(posedge clk) begin
        if (srst) begin
            flags_q <= FLAGS_RST;
        end else begin
            // R23 sticky until cleared
            flags_q <= (flags_q & ~flagClr) | flagSet;
        end
    end

    // Interrupt output
    always_ff @(posedge clk) begin
        if (srst) begin
            interruptN <= 1'b1;
        end else begin
            // R13 any flag interrupts
            interruptN <= ~(|flags_q);
        end
    end

    // Copy one-shot; retrigger restarts the full width
    always_ff @(posedge clk) begin
        if (srst) begin
            copyCnt_q <= 32'h00000000;
        // R14 data bit fires one-shot
        end else if (statWr && pin_q.wdata[WR_COPY_BIT]) begin
            copyCnt_q <= 32'(COPY_CYCLES);
        end else if (copyCnt_q != 32'h00000000) begin
            copyCnt_q <= copyCnt_q - 32'h00000001;
        end
    end

    // Copy pulse and busy hold-down while one-shot runs
    always_ff @(posedge clk) begin
        if (srst) begin
            copyStartPulseN <= 1'b1;
            copierBusyOut   <= 1'b0;
            copierBusyOe    <= 1'b0;
        end else begin
            // R15 start pulse, busy held low
            copyStartPulseN <= ~(copyCnt_q != 32'h00000000);
            copierBusyOut   <= 1'b0;
            copierBusyOe    <= (copyCnt_q != 32'h00000000);
        end
    end

    // Column counter: reload in retrace, count pixels
    always_ff @(posedge clk) begin
        if (srst) begin
            xCnt_q   <= CNT_ZERO;
            colHit_q <= 1'b0;
        // R16 reload each line retrace
        end else if (~pin_q.lineRetraceMarkerN) begin
            xCnt_q   <= column_q[14:0];
            colHit_q <= 1'b0;
        end else if (pixEdge) begin
            // R17 one pixel hit at zero
            colHit_q <= (xCnt_q == CNT_ONE);
            if (xCnt_q != CNT_ZERO) begin
                xCnt_q <= xCnt_q - CNT_ONE;
            end
        end
    end

    // Row counter: reload in frame retrace, count lines
    always_ff @(posedge clk) begin
        if (srst) begin
            yCnt_q   <= CNT_ZERO;
            rowHit_q <= 1'b0;
        // R19 reload in frame retrace
        end else if (~pin_q.frameRetraceMarkerN) begin
            yCnt_q   <= row_q[14:0];
            rowHit_q <= 1'b0;
        end else if (lineEdge) begin
            // R20 hit lasts one whole line
            rowHit_q <= (yCnt_q == CNT_ONE);
            if (yCnt_q != CNT_ZERO) begin
                yCnt_q <= yCnt_q - CNT_ONE;
            end
        end
    end

    // Cursor latch, sampled on cursor pixel clock
    always_ff @(posedge clk) begin
        if (srst) begin
            cursorVideo <= 1'b0;
        // R22 held off without enables
        end else if (pin_q.mapWriteSelN || !column_q[CURSOR_EN_BIT]) begin
            cursorVideo <= 1'b0;
        end else if (pixEdge) begin
            // R21 column or bordered row
            // R20 row overrides column
            cursorVideo <= colHit_q | (rowHit_q & pin_q.borderBlank);
        end
    end
endmodule

// File: dbsc_assertions.sv
`timescale 1ns/1ps
module dbsc_assertions
    import vc_bus_pkg::*;
#(
    parameter int COPY_CYCLES = 20
) (
    input wire logic              clk,
    input wire logic              srst,
    input wire vc_bus_pkg::pins_t pinsIn,
    input wire logic              rasterAddrOe,
    input wire logic              refreshAddressEnableN,
    input wire logic              refreshCycleN,
    input wire logic              vectorStepClock,
    input wire logic              vectorMemoryEnableN,
    input wire logic              vectorGrantAckN,
    input wire logic              groupSelectN,
    input wire logic              busAckN,
    input wire logic              ioDataOe,
    input wire logic              copyStartPulseN,
    input wire logic              copierBusyOut,
    input wire logic              copierBusyOe,
    input wire logic              cursorVideo
);
    logic inGrp;  // Address in the shared group
    int   lowCnt; // Cycles the copy pulse has been low

    assign inGrp = (pinsIn.addr[15:11] == GROUP_MATCH);

    // Pulse width counter, cleared whenever the pulse is idle
    always_ff @(posedge clk) begin
        if (srst || copyStartPulseN) begin
            lowCnt <= 0;
        end else begin
            lowCnt <= lowCnt + 1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // Pins held long enough to cross the synchroniser
    sequence grpHeld; inGrp[*5]; endsequence
    sequence outHeld; (!inGrp)[*5]; endsequence
    sequence readStatus; (!pinsIn.readCmdN && pinsIn.addr == ADDR_STATUS)[*4]; endsequence
    sequence busIdle; (pinsIn.readCmdN && pinsIn.writeSyncAckN)[*5]; endsequence

    group_select_a: assert property (grpHeld |-> !groupSelectN)
        else $error("group select missing");
    out_group_a: assert property (outHeld |-> groupSelectN && busAckN)
        else $error("group select outside range");
    status_read_a: assert property (readStatus |-> !busAckN && ioDataOe)
        else $error("status read not driven");
    idle_ack_a: assert property (busIdle |-> busAckN && !ioDataOe)
        else $error("ack or driver while idle");
    raster_drive_a: assert property (rasterAddrOe == !refreshAddressEnableN
        && refreshAddressEnableN == refreshCycleN)
        else $error("raster drive mismatch");
    owner_excl_a: assert property (!(!refreshCycleN && !vectorMemoryEnableN))
        else $error("two cycle owners");
    grant_cycle_a: assert property (!vectorGrantAckN |-> !vectorMemoryEnableN)
        else $error("grant outside vector cycle");
    vector_end_a: assert property ($rose(vectorMemoryEnableN) |-> ##[0:3] vectorStepClock)
        else $error("no step pulse at cycle end");
    copy_busy_a: assert property (copierBusyOe == !copyStartPulseN && !copierBusyOut)
        else $error("copier busy hold mismatch");
    copy_width_a: assert property ($rose(copyStartPulseN)
        |-> lowCnt inside {[COPY_CYCLES - 1:COPY_CYCLES + 1]})
        else $error("copy pulse width wrong");
    cursor_blank_a: assert property (pinsIn.mapWriteSelN[*5] |-> !cursorVideo)
        else $error("cursor shown while deselected");
endmodule

bind display_bus_status_cursor dbsc_assertions #(.COPY_CYCLES(COPY_CYCLES)) dbsc_assertions_i (
    .clk, .srst, .pinsIn, .rasterAddrOe, .refreshAddressEnableN, .refreshCycleN,
    .vectorStepClock, .vectorMemoryEnableN, .vectorGrantAckN, .groupSelectN, .busAckN,
    .ioDataOe, .copyStartPulseN, .copierBusyOut, .copierBusyOe, .cursorVideo
);

// File: mem_cycle_model.sv
`timescale 1ns/1ps
module mem_cycle_model (
    input  wire logic clk,
    input  wire logic wantVector,
    input  wire logic vectorStepClock,
    output logic      cycleStart,
    output logic      grantTimeWindow,
    output logic      vectorCycleRequestN,
    output int        stepRises
);
    logic [2:0] phase = 3'h0;   // Position in an eight-clock memory cycle
    logic       stepOld = 1'b0; // Step clock at the previous edge
    int         rises = 0;      // Step pulses seen by the vector board

    assign vectorCycleRequestN = !wantVector;
    assign stepRises = rises;
    // Boundary in the first half, grant window late so it lands inside
    assign cycleStart = (phase < 3'h4);
    assign grantTimeWindow = (phase == 3'h5) || (phase == 3'h6);

    // Ring moves off the sampling edge, like the bench pins
    always @(negedge clk) begin
        phase <= phase + 3'h1;
    end

    // Board sequencer advances once per step clock rise
    always @(posedge clk) begin
        if (vectorStepClock === 1'b1 && stepOld === 1'b0) begin
            rises <= rises + 1;
        end
        stepOld <= vectorStepClock;
    end
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import vc_bus_pkg::*;
    localparam int COPY_N = 20; // Short one-shot keeps the run brief
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    pins_t       pins;   // Pins driven by the bench
    pins_t       pinsIn; // Bench pins merged with memory timing
    logic [13:0] refreshAddr = 14'h1A5C;
    logic        wantVector = 1'b0;
    logic        cycleStart, grantTimeWindow, vectorCycleRequestN;
    int          stepRises;
    logic [13:0] rasterAddrOut;
    logic [15:0] ioDataOut, rd;
    logic        rasterAddrOe, refreshAddressEnableN, refreshCycleN, vectorStepClock;
    logic        vectorMemoryEnableN, vectorGrantAckN, groupSelectN, busAckN, ioDataOe;
    logic        interruptN, copyStartPulseN, copierBusyOut, copierBusyOe, cursorVideo, oe;
    int          errTotal = 0;
    int          samplesChecked = 0;
    int          n, s0, fr, fv, g, rc, hits, at;
    logic [15:0] grpAddr [5] = '{16'hF000, 16'hF700, 16'hF7FE, 16'hF800, 16'hE740};
    logic        grpExp [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errTotal++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, (a), (b)); end end

    // Free-running board clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    display_bus_status_cursor #(.COPY_CYCLES(COPY_N)) display_bus_status_cursor_i (
        .clk, .srst, .pinsIn, .refreshAddr, .rasterAddrOut, .rasterAddrOe,
        .refreshAddressEnableN, .refreshCycleN, .vectorStepClock, .vectorMemoryEnableN,
        .vectorGrantAckN, .groupSelectN, .busAckN, .ioDataOut, .ioDataOe, .interruptN,
        .copyStartPulseN, .copierBusyOut, .copierBusyOe, .cursorVideo);
    mem_cycle_model mem_cycle_model_i (
        .clk, .wantVector, .vectorStepClock, .cycleStart, .grantTimeWindow,
        .vectorCycleRequestN, .stepRises);

    // Memory timing pins come from the partner
    always_comb begin
        pinsIn = pins;
        pinsIn.cycleStart = cycleStart;
        pinsIn.grantTimeWindow = grantTimeWindow;
        pinsIn.vectorCycleRequestN = vectorCycleRequestN;
    end

    task automatic tick(input int c);
        repeat (c) @(negedge clk);
    endtask

    task automatic printVerdict();
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Write held until the synchroniser has passed it
    task automatic busWrite(input logic [15:0] a, input logic [15:0] d);
        pins.addr = a;
        pins.wdata = d;
        pins.writeCmdN = 1'b0;
        pins.writeSyncAckN = 1'b0;
        tick(5);
        `CHK(busAckN, 1'b0)
        pins.writeCmdN = 1'b1;
        pins.writeSyncAckN = 1'b1;
        tick(4);
    endtask

    // Read waits for the acknowledge under a bound
    task automatic busRead(input logic [15:0] a, output logic [15:0] d, output logic o);
        int k;
        pins.addr = a;
        pins.readCmdN = 1'b0;
        for (k = 0; k < 10 && busAckN !== 1'b0; k++) tick(1);
        if (k == 10) begin
            errTotal++;
            printVerdict();
        end else begin
            tick(1);
            d = ioDataOut;
            o = ioDataOe;
            pins.readCmdN = 1'b1;
            tick(4);
        end
    endtask

    // One line: retrace reload, then eight cursor pixels
    task automatic scanLine(output int h, output int p);
        h = 0;
        p = -1;
        pins.lineRetraceMarkerN = 1'b0;
        tick(5);
        pins.lineRetraceMarkerN = 1'b1;
        tick(2);
        for (int i = 0; i < 8; i++) begin
            pins.cursorPixelClock = 1'b1;
            tick(4);
            if (cursorVideo === 1'b1) begin
                h++;
                p = i;
            end
            pins.cursorPixelClock = 1'b0;
            tick(4);
        end
    endtask

    // Hang guard well past the longest sequence
    initial begin
        #400us;
        errTotal++;
        printVerdict();
    end

    initial begin
        pins = '0;
        pins.readCmdN = 1'b1;
        pins.writeCmdN = 1'b1;
        pins.writeSyncAckN = 1'b1;
        pins.lineRetraceMarkerN = 1'b1;
        pins.frameRetraceMarkerN = 1'b1;
        pins.addr = 16'hE000;
        tick(4);
        srst = 1'b0;
        tick(6);
        `CHK(interruptN, 1'b1)
        for (int i = 0; i < 5; i++) begin
            pins.addr = grpAddr[i];
            tick(5);
            `CHK(groupSelectN, grpExp[i])
        end
        s0 = stepRises;
        tick(40);
        n = stepRises - s0;
        `CHK(n >= 9 && n <= 11, 1'b1)
        // Unmapped write must not enable anything
        busWrite(16'hF748, 16'hFFFF);
        pins.frameSync = 1'b1;
        tick(5);
        pins.frameSync = 1'b0;
        tick(5);
        `CHK(interruptN, 1'b1)
        busRead(ADDR_CONTROL, rd, oe);
        `CHK(oe, 1'b0)
        busWrite(ADDR_CONTROL, 16'h0007);
        pins.frameSync = 1'b1;
        tick(5);
        pins.frameSync = 1'b0;
        tick(8);
        `CHK(interruptN, 1'b0)
        busRead(ADDR_STATUS, rd, oe);
        `CHK(rd[3:0], 4'h4)
        busWrite(ADDR_STATUS, 16'h0004);
        `CHK(interruptN, 1'b1)
        pins.vectorUnitReady = 1'b1;
        tick(6);
        busRead(ADDR_STATUS, rd, oe);
        `CHK(rd[3:0], 4'h9)
        busWrite(ADDR_STATUS, 16'h0008);
        `CHK(copyStartPulseN, 1'b0)
        tick(COPY_N);
        `CHK(copyStartPulseN, 1'b1)
        pins.copierBusyN = 1'b1;
        tick(6);
        busRead(ADDR_STATUS, rd, oe);
        `CHK(rd[2:0], 3'h3)
        busWrite(ADDR_STATUS, 16'h0007);
        `CHK(interruptN, 1'b1)
        // Refresh and vector requests arrive together
        fr = -1;
        fv = -1;
        g = 0;
        pins.refreshRequest = 1'b1;
        wantVector = 1'b1;
        for (int i = 0; i < 40; i++) begin
            tick(1);
            if (refreshCycleN === 1'b0 && fr < 0) fr = i;
            if (vectorMemoryEnableN === 1'b0 && fv < 0) fv = i;
            if (vectorGrantAckN === 1'b0) g++;
            if (refreshAddressEnableN === 1'b0) `CHK(rasterAddrOut, refreshAddr)
        end
        // Vector cycle must be the very next eight-clock memory cycle
        `CHK(fr >= 0 && fv - fr == 8, 1'b1)
        `CHK(g > 0, 1'b1)
        // Strap in: refresh requests keep coming but vector gets all cycles
        pins.refreshInhibitStrap = 1'b1;
        tick(5);
        s0 = stepRises;
        rc = 0;
        for (int i = 0; i < 48; i++) begin
            pins.refreshRequest = i[2];
            tick(1);
            if (refreshCycleN === 1'b0) rc++;
        end
        n = stepRises - s0;
        `CHK(rc, 0)
        `CHK(n >= 5 && n <= 7, 1'b1)
        wantVector = 1'b0;
        pins.refreshInhibitStrap = 1'b0;
        // Column cursor, reloaded on each of two lines
        busWrite(ADDR_COLUMN, 16'h8003);
        for (int i = 0; i < 2; i++) begin
            scanLine(hits, at);
            // Counter hits zero on pixel 2, latch shows it on pixel 3
            `CHK(hits, 1)
            `CHK(at, 3)
        end
        pins.mapWriteSelN = 1'b1;
        scanLine(hits, at);
        `CHK(hits, 0)
        pins.mapWriteSelN = 1'b0;
        busWrite(ADDR_COLUMN, 16'h0003);
        scanLine(hits, at);
        `CHK(hits, 0)
        // Row cursor on the first line after frame retrace
        busWrite(ADDR_COLUMN, 16'h8003);
        busWrite(ADDR_ROW, 16'h0001);
        pins.frameRetraceMarkerN = 1'b0;
        tick(5);
        pins.frameRetraceMarkerN = 1'b1;
        tick(5);
        pins.lineSync = 1'b1;
        tick(5);
        pins.lineSync = 1'b0;
        pins.borderBlank = 1'b1;
        tick(5);
        scanLine(hits, at);
        `CHK(hits, 8)
        printVerdict();
    end
endmodule
